// ### sps_pkg.sv
// Shared constants and types for the synthesizer serial programming block.
// Assumes one 25 MHz clock domain; the bus pins are synchronised on entry.
package sps_pkg;

  // ************************************************************
  // Register bus layout
  // ************************************************************
  localparam int AXI_AW = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DIV = 8'h04;
  localparam logic [7:0] REG_CB1 = 8'h08;
  localparam logic [7:0] REG_CB2 = 8'h0C;
  localparam logic [7:0] REG_STAT = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_EN_BIT = 2;

  // ************************************************************
  // Serial bus address and data byte layout
  // ************************************************************
  localparam logic [4:0] DEV_ADDR_BASE = 5'h18;
  localparam int BYTE_LEAD_BIT = 7;
  localparam int CB1_SEL_BIT = 6;
  localparam int CB1_TEST_LSB = 3;
  localparam int CB1_REF_LSB = 0;
  localparam int CB1_TC_BIT = 3;
  localparam int CB1_AGC_LSB = 0;
  localparam int CB2_CP_LSB = 5;
  localparam int CB2_PORT_LSB = 0;
  localparam logic [2:0] TEST_XTAL_ON = 3'h1;
  localparam logic [2:0] TEST_AUTO_LOOP = 3'h3;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [1:0] ADDR_SEL_RST = 2'h1;
  localparam logic EN_RST = 1'h1;
  localparam logic [14:0] DIV_RST = 15'h0000;
  localparam logic [2:0] FIELD3_RST = 3'h0;
  localparam logic AGC_TC_RST = 1'h0;
  localparam logic [4:0] PORT_RST = 5'h00;

  typedef enum logic [1:0] {EXP_ANY, EXP_DB2, EXP_CB2} sps_expect_t;

endpackage

// ### sps_if.sv
// Carriers between the top and its two helpers: received bytes and register access.
// Assumes all three modules share aclk.
`timescale 1ns/1ns
`default_nettype none

interface sps_byte_if;
  logic frame_start;
  logic frame_stop;
  logic byte_valid;
  logic [7:0] byte_data;
  logic busy;
  modport rx (output frame_start, frame_stop, byte_valid, byte_data, busy);
  modport dec (input frame_start, frame_stop, byte_valid, byte_data, busy);
endinterface

interface sps_reg_if;
  logic wr_stb;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_hit;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_hit;
  modport slv (output wr_stb, wr_addr, wr_data, wr_strb, rd_addr,
               input wr_hit, rd_data, rd_hit);
  modport regs (input wr_stb, wr_addr, wr_data, wr_strb, rd_addr,
                output wr_hit, rd_data, rd_hit);
endinterface

`default_nettype wire

// ### sps_i2c_rx.sv
// Serial bus receiver: START/STOP detection, address match, byte shift and acknowledge.
// Assumes SCL is driven only by the host; this end never stretches the clock.
`timescale 1ns/1ns
`default_nettype none

module sps_i2c_rx
  import sps_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_oe_n,
  input wire logic [1:0] addr_sel,
  input wire logic enable,
  sps_byte_if.rx bus
);

  typedef enum logic [1:0] {RX_IDLE, RX_SHIFT, RX_ACK} sps_rx_state_t;

  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
  logic addr_phase;
  logic [3:0] cnt;
  logic [7:0] shreg;
  sps_rx_state_t state;

  // Two-flop synchronisers; edges are taken from the second stage only.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {scl_s1, scl_s2, scl_d} <= 3'h7;
      {sda_s1, sda_s2, sda_d} <= 3'h7;
    end else if (ce) begin
      {scl_s1, scl_s2, scl_d} <= {scl_i, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_d} <= {sda_i, sda_s1, sda_s2};
    end
  end

  // Bus conditions seen on the synchronised lines.
  wire start_cond = scl_s2 && scl_d && sda_d && !sda_s2;
  wire stop_cond = scl_s2 && scl_d && !sda_d && sda_s2;
  wire scl_rise = scl_s2 && !scl_d;
  wire scl_fall = !scl_s2 && scl_d;
  wire byte_done = (state == RX_SHIFT) && scl_fall && (cnt == 4'h8);
  // Reads are refused: nothing in this path can be read back over the wire.
  wire addr_match = enable && (shreg == {DEV_ADDR_BASE, addr_sel, 1'b0});

  // Frame sequencer; the acknowledge is driven from the falling edge after bit eight.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= RX_IDLE;
      addr_phase <= 1'b0;
      cnt <= 4'h0;
      shreg <= 8'h00;
      sda_oe_n <= 1'b1;
      bus.busy <= 1'b0;
    end else if (ce) begin
      if (start_cond) begin
        state <= RX_SHIFT;
        addr_phase <= 1'b1;
        cnt <= 4'h0;
        sda_oe_n <= 1'b1;
        bus.busy <= 1'b1;
      end else if (stop_cond) begin
        state <= RX_IDLE;
        sda_oe_n <= 1'b1;
        bus.busy <= 1'b0;
      end else begin
        unique case (state)
          RX_IDLE: begin
            sda_oe_n <= 1'b1;
          end
          RX_SHIFT: begin
            if (scl_rise && cnt != 4'h8) begin
              shreg <= {shreg[6:0], sda_s2};
              cnt <= cnt + 4'h1;
            end
            if (byte_done) begin
              sda_oe_n <= addr_phase && !addr_match;
              state <= (addr_phase && !addr_match) ? RX_IDLE : RX_ACK;
            end
          end
          RX_ACK: begin
            if (scl_fall) begin
              sda_oe_n <= 1'b1;
              cnt <= 4'h0;
              addr_phase <= 1'b0;
              state <= RX_SHIFT;
            end
          end
        endcase
      end
    end
  end

  // One-cycle strobes towards the decoder; data byte flags a completed data byte.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus.frame_start <= 1'b0;
      bus.frame_stop <= 1'b0;
      bus.byte_valid <= 1'b0;
      bus.byte_data <= 8'h00;
    end else if (ce) begin
      bus.frame_start <= start_cond;
      bus.frame_stop <= stop_cond && bus.busy;
      bus.byte_valid <= byte_done && !addr_phase && !start_cond && !stop_cond;
      if (byte_done) begin
        bus.byte_data <= shreg;
      end
    end else begin
      bus.frame_start <= 1'b0;
      bus.frame_stop <= 1'b0;
      bus.byte_valid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ### sps_axil.sv
// AXI4-Lite slave front end; register storage and decode live in the top.
// Assumes one write and one read outstanding at most, per the bus rules.
`timescale 1ns/1ns
`default_nettype none

module sps_axil
  import sps_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  sps_reg_if.slv rif
);

  logic aw_held, w_held;

  // Address and data are taken in either order and held until both are in.
  assign awready = ce && !aw_held && !bvalid;
  assign wready = ce && !w_held && !bvalid;
  assign arready = ce && !rvalid;
  assign rif.wr_stb = ce && aw_held && w_held && !bvalid;
  assign rif.rd_addr = araddr;

  // Write path holding registers and response.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rif.wr_addr <= 8'h00;
      rif.wr_data <= 32'h0000_0000;
      rif.wr_strb <= 4'h0;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        rif.wr_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        rif.wr_data <= wdata;
        rif.wr_strb <= wstrb;
      end
      if (rif.wr_stb) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= rif.wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read path: data is captured on the address handshake.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata <= rif.rd_data;
        rresp <= rif.rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ### sps_top.sv
// Serial programming path of a tuner synthesizer: bytes from the bus host set divider,
// test, reference, AGC, charge pump and port settings; software watches over AXI4-Lite.
// Assumes SCL/SDA come from the board asynchronously and all logic runs on aclk.
// Functional notes
// - A frame is START, the address byte, data bytes and STOP, each byte acknowledged, and the address taken depends on the address select setting.
// - The divider ratio comes in two consecutive divider bytes, high part first, and such a pair alone changes only the divider.
// - Control byte 1 with its select bit at one loads the three test bits and the three reference ratio bits.
// - Control byte 1 with its select bit at zero loads the AGC time constant bit and the three take-over bits instead.
// - Divider and control byte pairs are accepted in any order within a frame and each byte acts by its type.
// - Control byte 2 carries charge pump current and port settings and may follow control byte 1.
// - Control byte 1 alone with the select bit at zero changes only the AGC fields.
// - Control values after the divider bytes can enable automatic loop bandwidth and normal mode with the crystal buffer off.
//
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module sps_top
  import sps_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [14:0] divider_ratio,
  output logic [2:0] test_bits,
  output logic [2:0] ref_divider_ratio,
  output logic agc_time_constant,
  output logic [2:0] agc_takeover_level,
  output logic [2:0] charge_pump_current,
  output logic [4:0] band_ports,
  output logic crystal_buffer_output,
  output logic auto_loop_bandwidth
);

  // ************************************************************
  // Helpers and byte receiver
  // ************************************************************
  sps_byte_if bif ();
  sps_reg_if rif ();

  logic [1:0] addr_sel;
  logic bus_enable;
  logic [6:0] div_high_hold;
  logic [7:0] frame_count;
  sps_expect_t expect_q;

  // The pin is open drain: the output level is always low, the enable does the work.
  assign sda_o = 1'b0;

  sps_i2c_rx u_rx (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_oe_n(sda_oe_n),
    .addr_sel(addr_sel),
    .enable(bus_enable),
    .bus(bif.rx)
  );

  sps_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .rif(rif.slv)
  );

  // ************************************************************
  // Byte classification
  // ************************************************************
  // A byte that opens a pair is classed by its lead bit; its partner is taken by position,
  // which is why a second control byte of 8'h00 cannot be mistaken for a divider byte.
  wire take = ce && bif.byte_valid;
  wire [7:0] b = bif.byte_data;
  wire opens_pair = take && (expect_q == EXP_ANY);
  wire is_div_high = opens_pair && !b[BYTE_LEAD_BIT];
  wire is_cb1 = opens_pair && b[BYTE_LEAD_BIT];
  wire is_div_low = take && (expect_q == EXP_DB2);
  wire is_cb2 = take && (expect_q == EXP_CB2);
  wire cb1_test_sel = b[CB1_SEL_BIT];

  // Pair tracking restarts at every START so a broken frame leaves no half pair behind.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      expect_q <= EXP_ANY;
    end else if (ce && bif.frame_start) begin
      expect_q <= EXP_ANY;
    end else if (take) begin
      unique case (expect_q)
        EXP_ANY: expect_q <= b[BYTE_LEAD_BIT] ? EXP_CB2 : EXP_DB2;
        EXP_DB2: expect_q <= EXP_ANY;
        EXP_CB2: expect_q <= EXP_ANY;
      endcase
    end
  end

  // ************************************************************
  // Settings
  // ************************************************************
  // The divider changes only when the low byte lands, so a lone high byte never
  // leaves the synthesizer on a half-updated ratio.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_high_hold <= 7'h00;
      divider_ratio <= DIV_RST;
    end else begin
      if (is_div_high) begin
        div_high_hold <= b[6:0];
      end
      if (is_div_low) begin
        divider_ratio <= {div_high_hold, b};
      end
    end
  end

  // Control byte 1 steers one of two field groups by its select bit.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      test_bits <= FIELD3_RST;
      ref_divider_ratio <= FIELD3_RST;
      agc_time_constant <= AGC_TC_RST;
      agc_takeover_level <= FIELD3_RST;
    end else if (is_cb1) begin
      if (cb1_test_sel) begin
        test_bits <= b[CB1_TEST_LSB +: 3];
        ref_divider_ratio <= b[CB1_REF_LSB +: 3];
      end else begin
        agc_time_constant <= b[CB1_TC_BIT];
        agc_takeover_level <= b[CB1_AGC_LSB +: 3];
      end
    end
  end

  // Control byte 2 is only ever taken as the partner of control byte 1.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      charge_pump_current <= FIELD3_RST;
      band_ports <= PORT_RST;
    end else if (is_cb2) begin
      charge_pump_current <= b[CB2_CP_LSB +: 3];
      band_ports <= b[CB2_PORT_LSB +: 5];
    end
  end

  // Test codes pick the crystal buffer and loop bandwidth modes; all else is normal mode.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crystal_buffer_output <= 1'b0;
      auto_loop_bandwidth <= 1'b0;
    end else if (ce) begin
      crystal_buffer_output <= (test_bits == TEST_XTAL_ON);
      auto_loop_bandwidth <= (test_bits == TEST_AUTO_LOOP);
    end
  end

  // ************************************************************
  // Software registers
  // ************************************************************
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == REG_CTRL) || (a == REG_DIV) || (a == REG_CB1) ||
              (a == REG_CB2) || (a == REG_STAT);
  endfunction

  assign rif.wr_hit = reg_hit(rif.wr_addr);
  assign rif.rd_hit = reg_hit(rif.rd_addr);
  wire ctrl_wr = rif.wr_stb && (rif.wr_addr == REG_CTRL) && rif.wr_strb[0];
  wire [31:0] ctrl_word = {29'h0, bus_enable, addr_sel};
  wire [31:0] cb1_word = {21'h0, agc_takeover_level, 1'b0, agc_time_constant,
                          test_bits, ref_divider_ratio};
  wire [31:0] cb2_word = {22'h0, auto_loop_bandwidth, crystal_buffer_output,
                          charge_pump_current, band_ports};
  wire [31:0] stat_word = {14'h0, expect_q, frame_count, 7'h0, bif.busy};

  // Read selection; unmapped offsets read zero and answer with an error.
  assign rif.rd_data = (rif.rd_addr == REG_CTRL) ? ctrl_word :
                       (rif.rd_addr == REG_DIV) ? {17'h0, divider_ratio} :
                       (rif.rd_addr == REG_CB1) ? cb1_word :
                       (rif.rd_addr == REG_CB2) ? cb2_word :
                       (rif.rd_addr == REG_STAT) ? stat_word : 32'h0000_0000;

  // Address select and bus enable decide which address byte is acknowledged.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_sel <= ADDR_SEL_RST;
      bus_enable <= EN_RST;
    end else if (ctrl_wr) begin
      addr_sel <= rif.wr_data[CTRL_SEL_LSB +: 2];
      bus_enable <= rif.wr_data[CTRL_EN_BIT];
    end
  end

  // Completed frames counted at STOP, wrapping.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_count <= 8'h00;
    end else if (ce && bif.frame_stop) begin
      frame_count <= frame_count + 8'h01;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_div_high;
    is_div_high;
  endsequence
  sequence s_div_low;
    is_div_low;
  endsequence
  sequence s_cb1_agc;
    is_cb1 && !cb1_test_sel;
  endsequence

  a_byte_ack_drive: assert property (bif.byte_valid |-> !sda_oe_n)
    else $error("data byte not acknowledged");
  a_ack_released: assert property ($rose(bif.busy) |-> sda_oe_n)
    else $error("data line held at start of frame");
  a_div_high_wait: assert property (s_div_high |=> $stable(divider_ratio))
    else $error("divider moved on high byte");
  a_div_pair_load: assert property (s_div_low |=>
    divider_ratio == {$past(div_high_hold), $past(b)})
    else $error("divider pair not loaded");
  a_test_fields: assert property (is_cb1 && cb1_test_sel |=>
    test_bits == $past(b[5:3]) && ref_divider_ratio == $past(b[2:0]) &&
    $stable(agc_takeover_level))
    else $error("test or reference bits wrong");
  a_agc_fields: assert property (s_cb1_agc |=>
    agc_time_constant == $past(b[3]) && agc_takeover_level == $past(b[2:0]))
    else $error("AGC fields wrong");
  a_agc_only: assert property (s_cb1_agc |=> $stable(test_bits) &&
    $stable(ref_divider_ratio) && $stable(divider_ratio) && $stable(band_ports))
    else $error("AGC-only byte touched other settings");
  a_frame_restart: assert property (ce && bif.frame_start |=> expect_q == EXP_ANY)
    else $error("pair tracking not reset at start");
  // Control byte 1 must arm the pairing for control byte 2 and leave its fields alone.
  a_cb2_pairing: assert property (is_cb1 |=> expect_q == EXP_CB2 &&
    $stable({charge_pump_current, band_ports}))
    else $error("control byte 1 did not arm control byte 2");
  a_cb2_load: assert property (is_cb2 |=> {charge_pump_current, band_ports} == $past(b))
    else $error("control byte 2 not applied");
  a_lead_bit: assert property (opens_pair |=>
    expect_q == ($past(b[7]) ? EXP_CB2 : EXP_DB2))
    else $error("lead bit misclassified");
  a_auto_loop: assert property (is_cb1 && cb1_test_sel && b[5:3] == TEST_AUTO_LOOP
    |-> ##2 auto_loop_bandwidth && !crystal_buffer_output)
    else $error("loop bandwidth mode not entered");

endmodule

`default_nettype wire

// ### sps_host_model.sv
// Bus host model that writes whole byte frames to the device.
// Assumes a pull-up resolves SDA from the host and device drivers.
`timescale 1ns/1ns
`default_nettype none

module sps_host_model (
  input wire logic aclk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv
);
  // Slow bit timing leaves room for the device's pin synchronisers.
  task automatic tick();
    repeat (6) @(posedge aclk);
  endtask

  // START, n bytes each with an acknowledge slot, then STOP.
  task automatic frame(input logic [7:0] b [6], input int n, output int acks);
    acks = 0;
    sda_drv <= 1'b0;
    tick();
    scl <= 1'b0;
    tick();
    for (int k = 0; k < n; k++) begin
      for (int i = 8; i >= 0; i--) begin
        sda_drv <= (i == 0) ? 1'b1 : b[k][i-1];
        tick();
        scl <= 1'b1;
        tick();
        if (i == 0 && sda_line == 1'b0) acks++;
        scl <= 1'b0;
        tick();
      end
    end
    sda_drv <= 1'b0;
    tick();
    scl <= 1'b1;
    tick();
    sda_drv <= 1'b1;
    tick();
  endtask

  // Both lines idle high between frames.
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
endmodule

`default_nettype wire

// ### sps_top_bench.sv
// Bench for the serial programming block: host frames in, settings and registers checked.
// Assumes the package, interfaces, design and host model are compiled first.
`timescale 1ns/1ns
`default_nettype none

module sps_top_bench
  import sps_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic scl, sda_drv, sda_o, sda_oe_n;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [14:0] divider_ratio, e_div = 15'h0000;
  logic [2:0] test_bits, ref_divider_ratio, agc_takeover_level, charge_pump_current;
  logic [2:0] e_tst = 3'h0, e_ref = 3'h0, e_agc = 3'h0, e_cp = 3'h0;
  logic agc_time_constant, crystal_buffer_output, auto_loop_bandwidth;
  logic e_tc = 1'b0, e_xo = 1'b0, e_alb = 1'b0;
  logic [4:0] band_ports, e_prt = 5'h00;
  int bad_count = 0;
  int check_count = 0;
  // Open-drain line: either party pulling low wins over the pull-up.
  wire logic sda_line = sda_drv & (sda_oe_n | sda_o);
  wire logic [39:0] now_set = {5'h00, divider_ratio, test_bits, ref_divider_ratio,
    agc_time_constant, agc_takeover_level, charge_pump_current, band_ports,
    crystal_buffer_output, auto_loop_bandwidth};
  wire logic [39:0] exp_set = {5'h00, e_div, e_tst, e_ref, e_tc, e_agc, e_cp, e_prt, e_xo, e_alb};

  always #20 aclk = ~aclk;

  sps_top dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .divider_ratio(divider_ratio), .test_bits(test_bits),
    .ref_divider_ratio(ref_divider_ratio), .agc_time_constant(agc_time_constant),
    .agc_takeover_level(agc_takeover_level), .charge_pump_current(charge_pump_current),
    .band_ports(band_ports), .crystal_buffer_output(crystal_buffer_output),
    .auto_loop_bandwidth(auto_loop_bandwidth));

  sps_host_model host (.aclk(aclk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: saw %h expected %h", $time, got, exp);
    end
  endtask

  // One AXI transfer; readies are combinational, so they are sampled mid-cycle.
  task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    logic aw, w, ar, done;
    logic [1:0] rsp;
    logic [31:0] rd;
    int n;
    n = 0;
    done = 1'b0;
    if (wr) begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    while (!done && n < 50) begin
      @(negedge aclk);
      aw = awready;
      w = wready;
      ar = arready;
      done = wr ? bvalid : rvalid;
      rsp = wr ? bresp : rresp;
      rd = rdata;
      n++;
      @(posedge aclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (ar) arvalid <= 1'b0;
    end
    bready <= 1'b0;
    rready <= 1'b0;
    if (done !== 1'b1) begin
      bad_count++;
      $display("ERROR %0t: bus answer never came", $time);
      final_report();
    end
    chk({38'h0, rsp}, {38'h0, er});
    if (!wr) chk({8'h00, rd}, {8'h00, d});
    @(posedge aclk);
  endtask

  // Sends a frame, checks how many bytes were acknowledged and the settings after.
  task automatic send(input logic [7:0] b [6], input int n, input int acks_exp);
    int acks;
    host.frame(b, n, acks);
    chk(40'(acks), 40'(acks_exp));
    repeat (4) @(posedge aclk);
    chk(now_set, exp_set);
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    chk(now_set, 40'h0);
    axi(1'b0, REG_CTRL, 32'h0000_0005, RESP_OKAY);
  endtask

  task automatic t_divider_only();
    e_div = 15'h12C0;
    send('{8'hC2, 8'h12, 8'hC0, 8'h00, 8'h00, 8'h00}, 3, 3);
    axi(1'b0, REG_DIV, 32'h0000_12C0, RESP_OKAY);
  endtask

  // Control pair first, divider next, lone control byte last.
  task automatic t_any_order();
    {e_tst, e_ref, e_cp, e_prt, e_agc, e_xo} = {3'h1, 3'h2, 3'h5, 5'h04, 3'h4, 1'b1};
    send('{8'hC2, 8'hCA, 8'hA4, 8'h12, 8'hC0, 8'h84}, 6, 6);
    axi(1'b0, REG_CB1, 32'h0000_040A, RESP_OKAY);
    axi(1'b0, REG_CB2, 32'h0000_01A4, RESP_OKAY);
  endtask

  task automatic t_agc_only();
    {e_tc, e_agc} = {1'b1, 3'h3};
    send('{8'hC2, 8'h8B, 8'h00, 8'h00, 8'h00, 8'h00}, 2, 2);
    axi(1'b0, REG_CB1, 32'h0000_034A, RESP_OKAY);
    // Three frames ended so far; the lone control byte 1 leaves the pair state waiting.
    axi(1'b0, REG_STAT, 32'h0002_0300, RESP_OKAY);
  endtask

  task automatic t_auto_loop();
    {e_tst, e_cp, e_prt, e_xo, e_alb} = {3'h3, 3'h0, 5'h00, 1'b0, 1'b1};
    send('{8'hC2, 8'h12, 8'hC0, 8'hDA, 8'h00, 8'h00}, 5, 5);
    {e_tst, e_alb} = {3'h0, 1'b0};
    send('{8'hC2, 8'hC2, 8'h00, 8'h00, 8'h00, 8'h00}, 2, 2);
  endtask

  // Address select and bus enable, then unmapped places.
  task automatic t_address();
    axi(1'b1, REG_CTRL, 32'h0000_0004, RESP_OKAY);
    send('{8'hC2, 8'h12, 8'hC0, 8'h00, 8'h00, 8'h00}, 3, 0);
    e_div = 15'h0005;
    send('{8'hC0, 8'h00, 8'h05, 8'h00, 8'h00, 8'h00}, 3, 3);
    axi(1'b1, REG_CTRL, 32'h0000_0000, RESP_OKAY);
    send('{8'hC0, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00}, 3, 0);
    axi(1'b1, REG_CTRL, 32'h0000_0005, RESP_OKAY);
    axi(1'b0, 8'h14, 32'h0, RESP_SLVERR);
    axi(1'b1, 8'h18, 32'hFF, RESP_SLVERR);
  endtask

  // Reset is held two edges; the pin synchronisers load idle high on the first.
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_divider_only();
    t_any_order();
    t_agc_only();
    t_auto_loop();
    t_address();
    final_report();
  end

  // A hang anywhere ends the run as a failure.
  initial begin
    repeat (40000) @(posedge aclk);
    bad_count++;
    $display("ERROR %0t: run did not finish", $time);
    final_report();
  end
endmodule

`default_nettype wire
